// *** lvd_defines.svh ***
// constants for the four-lane 28-bit link receiver
`ifndef LVD_DEFINES_SVH
`define LVD_DEFINES_SVH

// ==========================================================================
// link shape
`define LVD_LANES 4
`define LVD_SLOTS 7
`define LVD_WORD_W 28

// ==========================================================================
// timing
`define LVD_CLK_PERIOD_NS 10
`define LVD_LOCK_TIME_MS 10
`define LVD_LOCK_CYCLES ((`LVD_LOCK_TIME_MS * 1000000) / `LVD_CLK_PERIOD_NS)
`define LVD_PDD_TIME_US 1
`define LVD_PDD_CYCLES ((`LVD_PDD_TIME_US * 1000) / `LVD_CLK_PERIOD_NS)
`define LVD_LOSS_TIME_NS 200
`define LVD_LOSS_CYCLES \
  ((`LVD_LOSS_TIME_NS + `LVD_CLK_PERIOD_NS - 1) / `LVD_CLK_PERIOD_NS)
`define LVD_PER_MIN_CYC 7

`endif

// *** lvd_pkg.sv ***
// types shared by the link receiver modules
`include "lvd_defines.svh"

package lvd_pkg;

  // ========================================================================
  // receiver states
  typedef enum logic [2:0] {
    ST_DOWN = 3'b001,
    ST_ACQ  = 3'b010,
    ST_LOCK = 3'b100
  } lvd_state_type;

  // ========================================================================
  // output bundle, registered as one
  typedef struct packed {
    logic strobe;
    logic [`LVD_WORD_W-1:0] word;
  } lvd_out_type;

endpackage

// *** lvd_lane_capture.sv ***
// one lane: stores each sampled serial bit into its slot
`include "lvd_defines.svh"

module lvd_lane_capture import lvd_pkg::*; #(
  parameter int SLOTS = `LVD_SLOTS
) (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic lane_bit, // synchronised lane level
  input wire logic take, // sample this cycle
  input wire logic [2:0] slot, // slot written on take
  output logic [SLOTS-1:0] bits // captured bits, bit 0 first in time
);

  logic [SLOTS-1:0] bits_q;
  logic [SLOTS-1:0] bits_d;

  // ========================================================================
  // slot store
  always_comb begin
    bits_d = bits_q;
    if (take && (slot < 3'(SLOTS))) begin
      bits_d[slot] = lane_bit;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bits_q <= '0;
    end else begin
      bits_q <= bits_d;
    end
  end

  assign bits = bits_q;

  // ========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  slot_store_a: assert property (
    take && slot < 3'(SLOTS) |=> bits_q[$past(slot)] == $past(lane_bit))
    else $error("sampled lane bit not stored in its slot");

endmodule // lvd_lane_capture

// *** lvd_deserializer.sv ***
// four-lane serial-to-parallel link receiver with clock tracking and lock
`include "lvd_defines.svh"

module lvd_deserializer import lvd_pkg::*; #(
  parameter int LOCK_CYCLES = `LVD_LOCK_CYCLES,
  parameter int LOSS_CYCLES = `LVD_LOSS_CYCLES
) (
  input wire logic ref_clk, // 100 MHz system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic forwarded_link_clock_in, // link clock from sender
  input wire logic [`LVD_LANES-1:0] serial_lane_in, // serial data lanes
  input wire logic power_down_n, // powerdown, active low
  output logic [`LVD_WORD_W-1:0] parallel_word_out, // recovered word
  output logic strobe_clock_out // rises when word is valid
);

  localparam int LANES = `LVD_LANES;
  localparam int SLOTS = `LVD_SLOTS;
  localparam int PW = 8;
  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam logic [PW-1:0] PER_MIN = PW'(`LVD_PER_MIN_CYC);
  localparam logic [2:0] SLOT_DONE = 3'(SLOTS);
  localparam logic [2:0] SLOT_LAST = 3'(SLOTS - 1);

  // ========================================================================
  // input synchronisers
  logic pd_s1_q;
  logic pd_s2_q;
  logic lk_s1_q;
  logic lk_s2_q;
  logic lk_s3_q;
  logic [LANES-1:0] ln_s1_q;
  logic [LANES-1:0] ln_s2_q;

  // lanes take the same two stages as the clock so edge and data stay aligned
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
      lk_s1_q <= 1'b0;
      lk_s2_q <= 1'b0;
      lk_s3_q <= 1'b0;
      ln_s1_q <= '0;
      ln_s2_q <= '0;
    end else begin
      pd_s1_q <= power_down_n;
      pd_s2_q <= pd_s1_q;
      lk_s1_q <= forwarded_link_clock_in;
      lk_s2_q <= lk_s1_q;
      lk_s3_q <= lk_s2_q;
      ln_s1_q <= serial_lane_in;
      ln_s2_q <= ln_s1_q;
    end
  end

  // ========================================================================
  // lane capture and word assembly
  logic take;
  logic [2:0] slot_eff;
  logic [SLOTS-1:0] lane_bits [LANES];
  logic [`LVD_WORD_W-1:0] word_w;

  // word bit lane*7+slot comes from that lane's slot; sender uses the same
  for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
    lvd_lane_capture #(
      .SLOTS(SLOTS)
    ) u_cap (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .lane_bit(ln_s2_q[ln]),
      .take(take),
      .slot(slot_eff),
      .bits(lane_bits[ln])
    );
    assign word_w[ln*SLOTS +: SLOTS] = lane_bits[ln];
  end

  // ========================================================================
  // clock tracking, lock and sampling
  lvd_state_type st_q;
  lvd_state_type st_d;
  logic [PW-1:0] cnt_q;
  logic [PW-1:0] cnt_d;
  logic [PW-1:0] per_q;
  logic [PW-1:0] per_d;
  logic [LW-1:0] lock_q;
  logic [LW-1:0] lock_d;
  logic [2:0] slot_q;
  logic [2:0] slot_d;
  logic load_q;
  logic load_d;
  logic pub_q;
  logic pub_d;
  logic rise;
  logic loss;
  logic stable;
  logic [15:0] pos_now;
  logic [15:0] pos_bit;

  always_comb begin
    rise = lk_s2_q & ~lk_s3_q;
    cnt_d = rise ? '0 : ((cnt_q == '1) ? cnt_q : cnt_q + 8'h01);
    per_d = rise ? cnt_q + 8'h01 : per_q;
    loss = cnt_q >= PW'(LOSS_CYCLES);
    stable = (per_d >= per_q - 8'h01) && (per_d <= per_q + 8'h01) &&
             (per_d >= PER_MIN) && (per_q != '0);
    slot_eff = rise ? 3'h0 : slot_q;
    // bit k centre sits at (2k+1)/14 of the measured period
    pos_now = (16'(cnt_d) + 16'h0001) * 16'h000e;
    pos_bit = (16'(slot_eff) * 16'h0002 + 16'h0001) * 16'(per_q);
    take = (st_q == ST_LOCK) && !loss && pd_s2_q &&
           (slot_eff < SLOT_DONE) && (pos_now > pos_bit);
    slot_d = take ? slot_eff + 3'h1 : slot_eff;
    st_d = st_q;
    lock_d = lock_q;
    case (st_q)
      ST_DOWN: begin
        lock_d = '0;
        slot_d = SLOT_DONE;
        st_d = ST_ACQ;
      end
      ST_ACQ: begin
        slot_d = SLOT_DONE;
        if (loss || (rise && !stable)) begin
          lock_d = '0;
        end else if (lock_q != LW'(LOCK_CYCLES - 1)) begin
          lock_d = lock_q + LW'(1);
        end else if (rise) begin
          st_d = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (loss || (rise && !stable)) begin
          st_d = ST_ACQ;
          lock_d = '0;
          slot_d = SLOT_DONE;
        end
      end
      default: begin
        st_d = ST_DOWN;
      end
    endcase
    if (!pd_s2_q) begin
      st_d = ST_DOWN;
      lock_d = '0;
      slot_d = SLOT_DONE;
    end
    // a word is only published after its last slot in one period
    load_d = take && (slot_eff == SLOT_LAST);
    pub_d = load_q && pd_s2_q;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_DOWN;
      cnt_q <= '0;
      per_q <= '0;
      lock_q <= '0;
      slot_q <= SLOT_DONE;
      load_q <= 1'b0;
      pub_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      per_q <= per_d;
      lock_q <= lock_d;
      slot_q <= slot_d;
      load_q <= load_d;
      pub_q <= pub_d;
    end
  end

  // ========================================================================
  // output register and strobe shaping
  lvd_out_type out_q;
  lvd_out_type out_d;
  logic [PW-1:0] hi_q;
  logic [PW-1:0] hi_d;

  always_comb begin
    out_d = out_q;
    hi_d = hi_q;
    if (load_q) begin
      out_d.word = word_w;
    end
    // strobe rises a cycle after the word, held high for half a period
    if (pub_q) begin
      out_d.strobe = 1'b1;
      hi_d = per_q >> 1;
    end else if (hi_q > 8'h01) begin
      hi_d = hi_q - 8'h01;
    end else if (hi_q == 8'h01) begin
      hi_d = '0;
      out_d.strobe = 1'b0;
    end
    // a stopped link clock brings no new load, so the word simply stays
    if (!pd_s2_q) begin
      out_d = '0;
      hi_d = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= '0;
      hi_q <= '0;
    end else begin
      out_q <= out_d;
      hi_q <= hi_d;
    end
  end

  assign parallel_word_out = out_q.word;
  assign strobe_clock_out = out_q.strobe;

  // ========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  pd_forces_low_a: assert property (
    !pd_s2_q |=> parallel_word_out == '0 && !strobe_clock_out)
    else $error("outputs not low during powerdown");

  pd_entry_delay_a: assert property (
    (!power_down_n)[*4] |-> parallel_word_out == '0 && !strobe_clock_out)
    else $error("powerdown output state not reached in time");

  lock_interval_a: assert property (
    $rose(st_q == ST_LOCK) |-> $past(lock_q) == LW'(LOCK_CYCLES - 1))
    else $error("lock declared before the lock interval");

  no_early_word_a: assert property (
    $changed(parallel_word_out) |->
      $past(load_q) || parallel_word_out == '0)
    else $error("word changed without a complete capture");

  word_before_strobe_a: assert property (
    load_q && pd_s2_q ##1 pd_s2_q |=>
      $rose(strobe_clock_out) && $stable(parallel_word_out))
    else $error("strobe did not follow the word by one cycle");

  clock_loss_hold_a: assert property (
    (loss && pd_s2_q) ##1 pd_s2_q |->
      $stable(parallel_word_out) && !$rose(strobe_clock_out))
    else $error("outputs moved after the link clock stopped");

  loss_unlocks_a: assert property (
    st_q == ST_LOCK && loss |=> st_q != ST_LOCK && lock_q == '0)
    else $error("lock kept after link clock loss");

  strobe_spacing_a: assert property (
    $rose(strobe_clock_out) |=> (!$rose(strobe_clock_out))[*6])
    else $error("strobe rose twice within one link period");

  sample_point_a: assert property (
    take |-> pos_now - 16'h000e <= pos_bit && slot_eff < SLOT_DONE)
    else $error("lane sampled outside its bit position");

  // all seven slots must land inside the one measured period
  seven_slots_a: assert property (
    load_d |-> !rise && cnt_d < per_q)
    else $error("word completed with missing slots");

endmodule // lvd_deserializer

// *** lvd_tx_model.sv ***
// behavioural four-lane sender that drives the link clock and lanes
module lvd_tx_model (
  input wire logic run, // send periods while high
  input wire logic [27:0] word, // word latched at each period start
  output logic link_clk, // forwarded link clock
  output logic [3:0] lanes // serial lanes
);
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================================================
  // serialiser
  logic [27:0] w;
  int s;
  int l;

  initial begin
    link_clk = 1'b0;
    lanes = 4'h0;
  end

  // 80 ns period, seven slots, bit 0 first; clock high for four slots
  always begin
    wait (run);
    while (run) begin
      w = word;
      for (s = 0; s < 7; s++) begin
        link_clk = (s < 4);
        for (l = 0; l < 4; l++) lanes[l] = w[l*7+s];
        #(80.0 / 7.0);
      end
    end
    // clock stands still; lanes no longer carry the last value
    link_clk = 1'b0;
    lanes = ~lanes;
  end
endmodule // lvd_tx_model

// *** test_lvds_28bit_deserializer.sv ***
// self-checking bench for the four-lane link receiver
`include "lvd_defines.svh"

module test_lvds_28bit_deserializer;
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================================================
  // signals
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_down_n = 1'b0;
  logic run = 1'b0;
  logic [27:0] word = 28'h0000000;
  logic link_clk;
  logic [3:0] lanes;
  logic [`LVD_WORD_W-1:0] parallel_word_out;
  logic strobe_clock_out;
  int mismatches = 0;
  int tests_run = 0;
  int rises = 0;
  int cyc = 0;
  int rise_cyc = 0;
  int last_gap = 0;
  logic [27:0] pats [8] = '{28'h0000001, 28'h0000040, 28'h0000080,
    28'h8000000, 28'h5555555, 28'haaaaaaa, 28'hfffffff, 28'h0000000};

  always #5 ref_clk = ~ref_clk;

  lvd_deserializer #(.LOCK_CYCLES(200), .LOSS_CYCLES(20)) lvd_deserializer_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .forwarded_link_clock_in(link_clk),
    .serial_lane_in(lanes),
    .power_down_n(power_down_n),
    .parallel_word_out(parallel_word_out),
    .strobe_clock_out(strobe_clock_out)
  );

  lvd_tx_model lvd_tx_model_i (
    .run(run),
    .word(word),
    .link_clk(link_clk),
    .lanes(lanes)
  );

  // ========================================================================
  // strobe monitor; cycle count moves off the sampling edge
  always @(negedge ref_clk) cyc <= cyc + 1;

  always @(posedge strobe_clock_out) begin
    rises = rises + 1;
    last_gap = cyc - rise_cyc;
    rise_cyc = cyc;
  end

  // ========================================================================
  // helpers
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_strobes(input int n);
    int start;
    start = rises;
    for (int i = 0; i < n * 20 && rises < start + n; i++) @(negedge ref_clk);
    check(28'(rises - start), 28'(n));
  endtask

  task automatic complete_run;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ========================================================================
  // scenarios
  task automatic t_lock;
    word = 28'h0a5c3e1;
    power_down_n = 1'b1;
    run = 1'b1;
    repeat (150) @(negedge ref_clk);
    check(28'(rises), 28'h0);
    check(parallel_word_out, 28'h0);
    // lock needs about 210 cycles; start counting strobes just before
    repeat (55) @(negedge ref_clk);
    wait_strobes(2);
    check(parallel_word_out, 28'h0a5c3e1);
  endtask

  // back-to-back periods, word changing every third strobe; single bits 0, 6, 7 and 27 plus alternating patterns check the map
  task automatic t_map;
    foreach (pats[i]) begin
      word = pats[i];
      wait_strobes(3);
      check(parallel_word_out, pats[i]);
      check(28'(last_gap), 28'h8);
    end
  endtask

  task automatic t_pd;
    int start;
    word = 28'h3c3c3c3;
    wait_strobes(2);
    power_down_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    check(parallel_word_out, 28'h0);
    check(28'(strobe_clock_out), 28'h0);
    start = rises;
    word = 28'h1234567;
    power_down_n = 1'b1;
    repeat (150) @(negedge ref_clk);
    check(28'(rises - start), 28'h0);
    check(parallel_word_out, 28'h0);
    repeat (55) @(negedge ref_clk);
    wait_strobes(2);
    check(parallel_word_out, 28'h1234567);
  endtask

  task automatic t_stop;
    int start;
    word = 28'h6f0e1d2;
    wait_strobes(2);
    run = 1'b0;
    repeat (40) @(negedge ref_clk);
    start = rises;
    check(parallel_word_out, 28'h6f0e1d2);
    check(28'(strobe_clock_out), 28'h0);
    repeat (40) @(negedge ref_clk);
    check(28'(rises - start), 28'h0);
    check(parallel_word_out, 28'h6f0e1d2);
  endtask

  // ========================================================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_lock();
    t_map();
    t_pd();
    t_stop();
    complete_run();
  end

  // all scenarios need well under 40 us
  initial begin
    #200us;
    mismatches++;
    complete_run();
  end
endmodule // test_lvds_28bit_deserializer
